// *** common/npecc_pkg.sv ***
`default_nettype none
package npecc_pkg;
    // register offsets within the peripheral window
    localparam logic [7:0] OFS_CODE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PAGE_SIZE_MODE = 8'h04;
    localparam logic [7:0] OFS_ERROR_STATUS = 8'h08;
    localparam logic [7:0] OFS_CHECK_BITS = 8'h0c;
    localparam logic [7:0] OFS_INV_CHECK_BITS = 8'h10;
    // field positions
    localparam int BIT_SW_CLEAR = 0;
    localparam int BIT_RECOVERABLE = 0;
    localparam int BIT_CODE_AREA = 1;
    localparam int BIT_MULTIPLE = 2;
    // values after reset
    localparam logic [1:0] RST_PAGE_LENGTH = 2'h0;
    localparam logic [15:0] RST_CHECK = 16'h0000;
    // page geometry: total words per page size code, and main-area words
    localparam logic [12:0] PAGE_WORDS_528 = 13'h0210;
    localparam logic [12:0] MAIN_WORDS_BASE = 13'h0200;
    // memory commands that restart the code
    localparam logic [7:0] CMD_PAGE_READ = 8'h00;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h80;
    localparam logic [15:0] ALL_LOC_ONES = 16'hffff;

    // one snooped cycle on the memory bus
    typedef struct packed {
        logic cmd_strobe;
        logic addr_strobe;
        logic data_strobe;
        logic [15:0] data;
    } npecc_snoop_t;

    // error flags as they sit in the status register
    typedef struct packed {
        logic multiple_error_flag;
        logic code_area_error_flag;
        logic recoverable_error_flag;
    } npecc_status_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_ADDR, ST_MAIN, ST_SPARE, ST_DONE
    } npecc_state_t;
endpackage : npecc_pkg
`default_nettype wire

// *** design/npecc_unit.sv ***
`default_nettype none
module npecc_unit
    import npecc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    input wire npecc_snoop_t snoop,
    input wire logic wide_bus
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // main-area words for a page size code: 512 << code
    function automatic logic [12:0] main_words(input logic [1:0] sel);
        main_words = MAIN_WORDS_BASE << sel;
    endfunction : main_words

    // line and column parity contribution of one word; {inverted, direct}
    function automatic logic [31:0] word_code(input logic [15:0] w, input logic [11:0] idx,
                                              input logic wide);
        logic [15:0] p;
        logic [15:0] n;
        logic wp;
        p = 16'h0000;
        n = 16'h0000;
        wp = wide ? ^w : ^w[7:0];
        for (int i = 0; i < 12; i++) begin
            if (idx[i]) begin
                p[4+i] = wp;
            end else begin
                n[4+i] = wp;
            end
        end
        for (int k = 0; k < 16; k++) begin
            if (wide || k < 8) begin
                for (int b = 0; b < 4; b++) begin
                    if (k[b]) begin
                        p[b] = p[b] ^ w[k];
                    end else begin
                        n[b] = n[b] ^ w[k];
                    end
                end
            end
        end
        word_code = {n, p};
    endfunction : word_code

    ////////////////////////////////////////////////////////////////////////////
    // state

    npecc_state_t state, next_state;
    logic is_read, next_is_read;
    logic [12:0] word_cnt, next_word_cnt;
    logic [1:0] spare_cnt, next_spare_cnt;
    logic [15:0] acc_p, next_acc_p, acc_n, next_acc_n;
    logic [31:0] stored, next_stored;
    logic [15:0] check_bits, next_check_bits, inv_check, next_inv_check;
    npecc_status_t status, next_status;
    logic [1:0] page_length_select, next_page_length_select;
    logic [31:0] next_prdata;
    logic wr_access, sw_clear, eval_now, rd_setup;
    logic [15:0] syn_p, syn_n;
    logic [31:0] contrib;

    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign sw_clear = wr_access && paddr == OFS_CODE_CONTROL && pwdata[BIT_SW_CLEAR];
    assign contrib = word_code(snoop.data, word_cnt[11:0], wide_bus);
    assign syn_p = acc_p ^ stored[15:0];
    assign syn_n = acc_n ^ stored[31:16];

    ////////////////////////////////////////////////////////////////////////////
    // page engine: restart, main-area count, spare code capture, evaluation

    always_comb begin
        next_state = state;
        next_is_read = is_read;
        next_word_cnt = word_cnt;
        next_spare_cnt = spare_cnt;
        next_acc_p = acc_p;
        next_acc_n = acc_n;
        next_stored = stored;
        next_check_bits = check_bits;
        next_inv_check = inv_check;
        next_status = status;
        eval_now = 1'b0;
        // software clear goes first so a same-cycle result still lands
        if (sw_clear) begin
            next_check_bits = RST_CHECK;
            next_inv_check = RST_CHECK;
            next_status = '0;
        end
        if (snoop.cmd_strobe && (snoop.data[7:0] == CMD_PAGE_READ ||
                                 snoop.data[7:0] == CMD_PAGE_PROGRAM)) begin
            // restart; any other command leaves the engine alone
            next_state = ST_WAIT_ADDR;
            next_is_read = snoop.data[7:0] == CMD_PAGE_READ;
            next_check_bits = RST_CHECK;
            next_inv_check = RST_CHECK;
            next_status = '0;
        end else begin
            unique case (state)
                ST_IDLE, ST_DONE: begin
                    // results stay frozen until a page read or page program command or a software clear
                end
                ST_WAIT_ADDR: begin
                    if (snoop.addr_strobe) begin
                        next_state = ST_MAIN;
                        next_word_cnt = '0;
                        next_spare_cnt = '0;
                        next_acc_p = RST_CHECK;
                        next_acc_n = RST_CHECK;
                    end
                end
                ST_MAIN: begin
                    if (snoop.data_strobe) begin
                        next_acc_p = acc_p ^ contrib[15:0];
                        next_acc_n = acc_n ^ contrib[31:16];
                        next_word_cnt = word_cnt + 13'h0001;
                        if (word_cnt == main_words(page_length_select) - 13'h0001) begin
                            if (is_read) begin
                                next_state = ST_SPARE;
                            end else begin
                                next_state = ST_DONE;
                                next_check_bits = next_acc_p;
                                next_inv_check = next_acc_n;
                            end
                        end
                    end
                end
                ST_SPARE: begin
                    // stored code follows the main area: low half, then inverted half
                    if (snoop.data_strobe) begin
                        next_stored = wide_bus ? {snoop.data, stored[31:16]}
                                               : {snoop.data[7:0], stored[31:8]};
                        next_spare_cnt = spare_cnt + 2'h1;
                        if (wide_bus ? spare_cnt == 2'h1 : spare_cnt == 2'h3) begin
                            next_state = ST_DONE;
                            eval_now = 1'b1;
                        end
                    end
                end
            endcase
        end
        if (eval_now) begin
            next_check_bits = (next_stored[15:0] ^ acc_p);
            next_inv_check = (next_stored[31:16] ^ acc_n);
            if ((next_check_bits | next_inv_check) == 16'h0000) begin
                next_status = '0;
            end else if ((next_check_bits ^ next_inv_check) == ALL_LOC_ONES) begin
                next_status.recoverable_error_flag = 1'b1;
            end else if ($onehot({next_inv_check, next_check_bits})) begin
                next_status.code_area_error_flag = 1'b1;
            end else begin
                next_status.recoverable_error_flag = 1'b1;
                next_status.multiple_error_flag = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            is_read <= 1'b0;
            word_cnt <= '0;
            spare_cnt <= '0;
            acc_p <= RST_CHECK;
            acc_n <= RST_CHECK;
            stored <= '0;
            check_bits <= RST_CHECK;
            inv_check <= RST_CHECK;
            status <= '0;
        end else begin
            state <= next_state;
            is_read <= next_is_read;
            word_cnt <= next_word_cnt;
            spare_cnt <= next_spare_cnt;
            acc_p <= next_acc_p;
            acc_n <= next_acc_n;
            stored <= next_stored;
            check_bits <= next_check_bits;
            inv_check <= next_inv_check;
            status <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bank: read data is fetched in setup so it stands in access

    always_comb begin
        next_page_length_select = page_length_select;
        next_prdata = prdata;
        if (wr_access && paddr == OFS_PAGE_SIZE_MODE) begin
            next_page_length_select = pwdata[1:0];
        end
        if (rd_setup) begin
            unique case (paddr)
                OFS_PAGE_SIZE_MODE: next_prdata = {30'h0, page_length_select};
                OFS_ERROR_STATUS: next_prdata = {29'h0, status};
                OFS_CHECK_BITS: next_prdata = {16'h0, check_bits};
                OFS_INV_CHECK_BITS: next_prdata = {16'h0, inv_check};
                default: next_prdata = 32'h0; // control is write-only
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            page_length_select <= RST_PAGE_LENGTH;
            prdata <= 32'h0;
        end else begin
            page_length_select <= next_page_length_select;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_sw_clear_regs: assert property (@(posedge clk) disable iff (srst)
        sw_clear && !eval_now && state != ST_MAIN |=> check_bits == 16'h0 && inv_check == 16'h0)
        else $error("software clear left check registers set");

    chk_mode_written: assert property (@(posedge clk) disable iff (srst)
        wr_access && paddr == OFS_PAGE_SIZE_MODE |=> page_length_select == $past(pwdata[1:0]))
        else $error("page size write not taken");

    chk_cmd_restart: assert property (@(posedge clk) disable iff (srst)
        snoop.cmd_strobe && snoop.data[7:0] == CMD_PAGE_PROGRAM
        |=> state == ST_WAIT_ADDR && status == '0 && check_bits == 16'h0)
        else $error("program command did not restart the unit");

    chk_main_end: assert property (@(posedge clk) disable iff (srst)
        state == ST_MAIN && snoop.data_strobe && !snoop.cmd_strobe &&
        word_cnt == main_words(page_length_select) - 13'h0001
        |=> state == (is_read ? ST_SPARE : ST_DONE))
        else $error("main area end missed");

    chk_frozen_result: assert property (@(posedge clk) disable iff (srst)
        state == ST_DONE && !snoop.cmd_strobe && !sw_clear |=> $stable(check_bits))
        else $error("result changed while frozen");

    chk_mult_implies_rec: assert property (@(posedge clk) disable iff (srst)
        status.multiple_error_flag |-> status.recoverable_error_flag)
        else $error("multiple error without error flag");

    chk_single_location: assert property (@(posedge clk) disable iff (srst)
        eval_now ##1 status.recoverable_error_flag && !status.multiple_error_flag
        |-> (check_bits ^ inv_check) == ALL_LOC_ONES)
        else $error("single error location inconsistent");

    chk_code_area_onehot: assert property (@(posedge clk) disable iff (srst)
        $rose(status.code_area_error_flag) |-> $onehot({inv_check, check_bits}))
        else $error("code area error without single bit");

    chk_unmapped_zero: assert property (@(posedge clk) disable iff (srst)
        rd_setup && paddr > OFS_INV_CHECK_BITS |=> prdata == 32'h0)
        else $error("unmapped read not zero");

endmodule : npecc_unit
`default_nettype wire

// *** dv/npecc_flash_model.sv ***
`default_nettype none
module npecc_flash_model
    import npecc_pkg::*;
(
    input wire logic clk,
    output npecc_snoop_t snoop
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        snoop = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one bus cycle per clock, entered just after a rising edge
    task automatic put(input logic [2:0] s, input logic [15:0] v);
        snoop = {s, v};
        @(posedge clk);
        #1;
    endtask : put

    // released bus shows the inverse, so stale data cannot pass as valid
    task automatic rel();
        snoop = {3'b000, ~snoop.data};
        @(posedge clk);
        #1;
    endtask : rel

    // whole page from a page boundary; errors are single flipped bits, w = -1 for none
    task automatic page(input logic [7:0] cmd, input int words, input logic wide, input int w0,
                        input int k0, input int w1, input int k1, input logic [31:0] code);
        logic [15:0] v;
        put(3'b100, {8'h00, cmd});
        put(3'b010, 16'h0000);
        for (int w = 0; w < words; w++) begin
            v = ((w == w0) ? 16'h0001 << k0 : 16'h0000) ^
                ((w == w1) ? 16'h0001 << k1 : 16'h0000);
            put(3'b001, v);
        end
        // stored code {inverted, check} must follow the main area at once
        for (int i = 0; i < (wide ? 2 : 4); i++) begin
            if (cmd == CMD_PAGE_READ) begin
                put(3'b001, wide ? code[16*i +: 16] : {8'h00, code[8*i +: 8]});
            end
        end
        rel();
    endtask : page
endmodule : npecc_flash_model
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
module testbench
    import npecc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic wide_bus = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rv;
    npecc_snoop_t snoop;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'hfc};

    npecc_unit DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .snoop(snoop), .wide_bus(wide_bus));
    npecc_flash_model flash (.clk(clk), .snoop(snoop));

    initial begin
        forever begin
            #5 clk = ~clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks run %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one transfer plus an idle cycle; read data lands in rv at the end of access
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel = 1'b1;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(posedge clk);
        #1;
        penable = 1'b1;
        @(posedge clk);
        rv = prdata;
        #1;
        psel = 1'b0;
        penable = 1'b0;
        @(posedge clk);
        #1;
    endtask : apb

    // location word expected for one bit k of word w
    function automatic logic [31:0] loc(input int w, input int k);
        return {16'h0000, w[11:0], k[3:0]};
    endfunction : loc

    // status, check bits and inverted check bits, each against its own expectation
    task automatic res(input logic [31:0] st, input logic [31:0] ck, input logic [31:0] nk);
        apb(1'b0, OFS_ERROR_STATUS, 32'h0);
        check(rv, st);
        apb(1'b0, OFS_CHECK_BITS, 32'h0);
        check(rv, ck);
        apb(1'b0, OFS_INV_CHECK_BITS, 32'h0);
        check(rv, nk);
    endtask : res

    ////////////////////////////////////////////////////////////////////////////////
    // reset values, then writes everywhere; only the mode field may keep a value
    task automatic t_regs();
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0);
            check(rv, 32'h0);
            apb(1'b1, offs[i], 32'hffffffff);
            apb(1'b0, offs[i], 32'h0);
            check(rv, (offs[i] == OFS_PAGE_SIZE_MODE) ? 32'h3 : 32'h0);
        end
    endtask : t_regs

    // one set bit in the last main word of every page length, then freeze and clear
    task automatic t_prog();
        int k;
        for (int sz = 0; sz < 4; sz++) begin
            k = wide_bus ? 15 - sz : 7 - sz;
            apb(1'b1, OFS_PAGE_SIZE_MODE, 32'(sz));
            apb(1'b0, OFS_PAGE_SIZE_MODE, 32'h0);
            check(rv, 32'(sz));
            flash.page(CMD_PAGE_PROGRAM, 512 << sz, wide_bus, (512 << sz) - 1, k, -1, 0, 32'h0);
            res(32'h0, loc((512 << sz) - 1, k),
                loc((512 << sz) - 1, k) ^ 32'h0000ffff);
        end
        flash.put(3'b001, 16'h00ff);
        flash.rel();
        res(32'h0, loc(4095, k), loc(4095, k) ^ 32'h0000ffff);
        apb(1'b1, OFS_CODE_CONTROL, 32'h0);
        res(32'h0, loc(4095, k), loc(4095, k) ^ 32'h0000ffff);
        apb(1'b1, OFS_CODE_CONTROL, 32'h1);
        apb(1'b0, OFS_CODE_CONTROL, 32'h0);
        check(rv, 32'h0);
        res(32'h0, 32'h0, 32'h0);
    endtask : t_prog

    // clean page, single data error, code-area error and double error on read-back
    task automatic t_read();
        int k;
        k = wide_bus ? 14 : 6;
        apb(1'b1, OFS_PAGE_SIZE_MODE, 32'h0);
        // stored code matches the data, so the syndrome is zero in both halves
        flash.page(CMD_PAGE_READ, 512, wide_bus, 511, k, -1, 0,
                   ((loc(511, k) ^ 32'h0000ffff) << 16) | loc(511, k));
        res(32'h0, 32'h0, 32'h0);
        flash.page(CMD_PAGE_READ, 512, wide_bus, 511, k, -1, 0, 32'h0);
        res(32'h1, loc(511, k), loc(511, k) ^ 32'h0000ffff);
        flash.page(CMD_PAGE_READ, 512, wide_bus, -1, 0, -1, 0, 32'h00000001);
        res(32'h2, 32'h1, 32'h0);
        flash.page(CMD_PAGE_READ, 512, wide_bus, 5, 1, 9, 2, 32'h0);
        res(32'h5, loc(5, 1) ^ loc(9, 2), loc(5, 1) ^ loc(9, 2));
        flash.put(3'b100, 16'h0070);
        flash.rel();
        res(32'h5, loc(5, 1) ^ loc(9, 2), loc(5, 1) ^ loc(9, 2));
        flash.put(3'b100, {8'h00, CMD_PAGE_PROGRAM});
        flash.rel();
        res(32'h0, 32'h0, 32'h0);
    endtask : t_read

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        t_regs();
        for (int w = 0; w < 2; w++) begin
            wide_bus = w[0];
            t_prog();
            t_read();
        end
        stop_test();
    end

    // about 20k cycles are expected, so this limit only trips on a hang
    initial begin
        #500us;
        n_mismatch++;
        stop_test();
    end
endmodule : testbench
`default_nettype wire
